/* File: design/cies_pkg.sv */
// Constants and types for the interrupt and exception sequencer.
// Overview of operation
// (RL1) 256 types, 0 to 255, each with a four-byte vector entry.
// (RL2) Vector entry holds handler code segment and instruction pointer.
// (RL3) Entry: push status word, clear step/enable, push segment, pointer.
// (RL4) Return pops pointer and segment, then status word, resumes there.
// (RL5) Non-maskable is top interrupt, ignores enable flag, uses type 2.
// (RL6) Non-maskable pin is async, edge-triggered, latched; held a period.
// (RL7) Every non-maskable edge gets its own handler run; nesting unlimited. Here the pending count stops at 255; further edges are dropped.
// (RL8) Maskable request taken only while enable flag is set.
// (RL9) Controller merges maskable sources and supplies the vector type.
// (RL10) Exception type is fixed per condition or given by software interrupt.
// (RL11) Faults serviced before execution; return points at faulting one.
// (RL12) Traps serviced after instruction; return points at next instruction.
// (RL13) Divide overflow or divide by zero raises trap type 0.
// (RL14) Instruction completing with single-step flag set raises trap type 1.
// (RL15) No step trap after prefixes, segment loads, or wait-for-test.
// (RL16) Step entry clears flag; return restores it so next step traps.
// (RL17) Interrupts are recognised only between instructions.
// (RL18) Non-maskable served before maskable at the same boundary.
// (RL19) Undefined opcode raises invalid-opcode exception type 6.
// (RL20) Entry at type times four, segment 0; pointer low word, segment next.
package cies_pkg;
  localparam int           TYPE_W       = 8;
  localparam int           NMI_CNT_W    = 8;
  localparam logic [7:0]   TYPE_DIVIDE  = 8'h00;
  localparam logic [7:0]   TYPE_STEP    = 8'h01;
  localparam logic [7:0]   TYPE_NMI     = 8'h02;
  localparam logic [7:0]   TYPE_INVALID = 8'h06;
  localparam int           PSW_STEP_BIT = 8;
  localparam int           PSW_IE_BIT   = 9;
  localparam logic [15:0]  RESET_WORD   = 16'h0000;
  localparam logic [19:0]  VEC_IP_OFS   = 20'h00000;
  localparam logic [19:0]  VEC_CS_OFS   = 20'h00002;
  localparam logic [15:0]  STACK_STEP   = 16'h0002;

  typedef enum logic [3:0] {
    ST_IDLE, ST_ARB, ST_ACK, ST_PUSH_PSW, ST_PUSH_CS, ST_PUSH_IP,
    ST_RD_IP, ST_RD_CS, ST_POP_IP, ST_POP_CS, ST_POP_PSW, ST_RESUME
  } cies_state_t;
endpackage : cies_pkg

/* File: design/cies_nmi_if.sv */
// Carrier between the non-maskable catcher and the sequencer.
`timescale 1ns/1ns
interface cies_nmi_if;
  logic nmi_pend;
  logic nmi_take;
  modport catcher (output nmi_pend, input nmi_take);
  modport seq     (input nmi_pend, output nmi_take);
endinterface : cies_nmi_if

/* File: design/cies_nmi_catch.sv */
// Non-maskable pin synchroniser, edge detector and pending counter.
`timescale 1ns/1ns
module cies_nmi_catch (
  input  wire logic ref_clk,
  input  wire logic rst,
  input  wire logic nmi_pin,
  cies_nmi_if.catcher nmi
);
  logic                           sync1_q, sync2_q, last_q;
  logic                           edge_seen;
  logic [cies_pkg::NMI_CNT_W-1:0] cnt_q, cnt_d;

  // Pin is asynchronous; only the second stage is looked at
  assign edge_seen = sync2_q && !last_q; // RL6

  always_comb begin
    cnt_d = cnt_q;
    // Edge and take together leave the count alone, so no edge is lost
    if (edge_seen && !nmi.nmi_take && cnt_q != '1) begin
      cnt_d = cnt_q + 1'b1; // RL7
    end else if (!edge_seen && nmi.nmi_take && cnt_q != '0) begin
      cnt_d = cnt_q - 1'b1; // RL7
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      last_q  <= 1'b0;
      cnt_q   <= '0;
    end else begin
      sync1_q <= nmi_pin;
      sync2_q <= sync1_q;
      last_q  <= sync2_q;
      cnt_q   <= cnt_d;
    end
  end

  assign nmi.nmi_pend = (cnt_q != '0);
endmodule : cies_nmi_catch

/* File: design/cies_sequencer.sv */
// Interrupt and exception sequencer: entry, vectoring and return.
`timescale 1ns/1ns
module cies_sequencer (
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic        nmi_pin,
  input  wire logic        intr_req,
  output logic             intr_ack,
  input  wire logic        intr_type_valid,
  input  wire logic [7:0]  intr_type,
  input  wire logic        instr_done,
  input  wire logic        return_from_handler_req,
  input  wire logic        no_step_instr,
  input  wire logic        div_error,
  input  wire logic        undef_opcode,
  input  wire logic        sw_int,
  input  wire logic [7:0]  sw_type,
  input  wire logic        fault_req,
  input  wire logic [7:0]  fault_type,
  input  wire logic [15:0] cur_psw,
  input  wire logic [15:0] cur_cs,
  input  wire logic [15:0] cur_ip,
  input  wire logic [15:0] next_ip,
  input  wire logic [15:0] cur_ss,
  input  wire logic [15:0] cur_sp,
  output logic             seq_busy,
  output logic             load_valid,
  output logic [15:0]      new_psw,
  output logic [15:0]      new_cs,
  output logic [15:0]      new_ip,
  output logic [15:0]      new_sp,
  output logic             mem_req,
  output logic             mem_we,
  output logic [19:0]      mem_addr,
  output logic [15:0]      mem_wdata,
  input  wire logic        mem_ack,
  input  wire logic [15:0] mem_rdata
);
  cies_nmi_if nmi ();

  cies_nmi_catch u_nmi (
    .ref_clk (ref_clk),
    .rst     (rst),
    .nmi_pin (nmi_pin),
    .nmi     (nmi.catcher)
  );

  cies_pkg::cies_state_t st_q, st_d;
  logic [15:0] psw_q, psw_d, cs_q, cs_d, ip_q, ip_d;
  logic [15:0] ss_q, ss_d, sp_q, sp_d;
  logic [7:0]  vec_q, vec_d, exc_type_q, exc_type_d;
  logic        exc_v_q, exc_v_d, step_v_q, step_v_d;
  logic        done_q, done_d, mem_req_d, mem_we_d;
  logic [19:0] mem_addr_d, vec_base;
  logic [15:0] mem_wdata_d;
  logic        xfer;

  assign xfer     = mem_req && mem_ack;
  assign vec_base = {10'h000, vec_q, 2'b00}; // RL20

  always_comb begin
    st_d        = st_q;
    psw_d       = psw_q;
    cs_d        = cs_q;
    ip_d        = ip_q;
    ss_d        = ss_q;
    sp_d        = sp_q;
    vec_d       = vec_q;
    exc_v_d     = exc_v_q;
    exc_type_d  = exc_type_q;
    step_v_d    = step_v_q;
    done_d      = 1'b0;
    nmi.nmi_take = 1'b0;
    unique case (st_q)
      cies_pkg::ST_IDLE: begin
        if (return_from_handler_req) begin
          ss_d     = cur_ss;
          sp_d     = cur_sp;
          exc_v_d  = 1'b0;
          step_v_d = 1'b0;
          st_d     = cies_pkg::ST_POP_IP; // RL4
        end else if (instr_done) begin // RL17
          psw_d   = cur_psw;
          cs_d    = cur_cs;
          ss_d    = cur_ss;
          sp_d    = cur_sp;
          ip_d    = fault_req ? cur_ip : next_ip; // RL11 RL12
          exc_v_d = fault_req || undef_opcode || div_error || sw_int;
          // Only one of these four is taken per boundary: fault first, then undefined opcode, then divide, then software
          if (fault_req) exc_type_d = fault_type; // RL10
          else if (undef_opcode) exc_type_d = cies_pkg::TYPE_INVALID; // RL19
          else if (div_error) exc_type_d = cies_pkg::TYPE_DIVIDE; // RL13
          else exc_type_d = sw_type; // RL10
          step_v_d = cur_psw[cies_pkg::PSW_STEP_BIT] && !no_step_instr
                     && !fault_req; // RL14 RL15
          st_d = cies_pkg::ST_ARB;
        end
      end
      // Each pass takes one event; chained entries stack handler addresses
      cies_pkg::ST_ARB: begin
        if (exc_v_q) begin
          exc_v_d = 1'b0;
          vec_d   = exc_type_q;
          st_d    = cies_pkg::ST_PUSH_PSW;
        end else if (nmi.nmi_pend) begin // RL5 RL18
          nmi.nmi_take = 1'b1; // RL7
          vec_d        = cies_pkg::TYPE_NMI; // RL5
          st_d         = cies_pkg::ST_PUSH_PSW;
        end else if (intr_req && psw_q[cies_pkg::PSW_IE_BIT]) begin // RL8
          st_d = cies_pkg::ST_ACK;
        end else if (step_v_q) begin
          step_v_d = 1'b0;
          vec_d    = cies_pkg::TYPE_STEP; // RL14
          st_d     = cies_pkg::ST_PUSH_PSW;
        end else begin
          st_d = cies_pkg::ST_RESUME;
        end
      end
      cies_pkg::ST_ACK: begin
        if (intr_type_valid) begin
          vec_d = intr_type; // RL9
          st_d  = cies_pkg::ST_PUSH_PSW;
        end
      end
      cies_pkg::ST_PUSH_PSW: begin
        if (xfer) begin
          sp_d = sp_q - cies_pkg::STACK_STEP;
          psw_d[cies_pkg::PSW_STEP_BIT] = 1'b0; // RL3 RL16
          psw_d[cies_pkg::PSW_IE_BIT]   = 1'b0; // RL3
          st_d = cies_pkg::ST_PUSH_CS;
        end
      end
      cies_pkg::ST_PUSH_CS: begin
        if (xfer) begin
          sp_d = sp_q - cies_pkg::STACK_STEP;
          st_d = cies_pkg::ST_PUSH_IP; // RL3
        end
      end
      cies_pkg::ST_PUSH_IP: begin
        if (xfer) begin
          sp_d = sp_q - cies_pkg::STACK_STEP;
          st_d = cies_pkg::ST_RD_IP;
        end
      end
      cies_pkg::ST_RD_IP: begin
        if (xfer) begin
          ip_d = mem_rdata; // RL2
          st_d = cies_pkg::ST_RD_CS;
        end
      end
      cies_pkg::ST_RD_CS: begin
        if (xfer) begin
          cs_d = mem_rdata; // RL2
          st_d = cies_pkg::ST_ARB;
        end
      end
      cies_pkg::ST_POP_IP: begin
        if (xfer) begin
          ip_d = mem_rdata;
          sp_d = sp_q + cies_pkg::STACK_STEP;
          st_d = cies_pkg::ST_POP_CS; // RL4
        end
      end
      cies_pkg::ST_POP_CS: begin
        if (xfer) begin
          cs_d = mem_rdata;
          sp_d = sp_q + cies_pkg::STACK_STEP;
          st_d = cies_pkg::ST_POP_PSW; // RL4
        end
      end
      cies_pkg::ST_POP_PSW: begin
        if (xfer) begin
          psw_d = mem_rdata; // RL4 RL16
          sp_d  = sp_q + cies_pkg::STACK_STEP;
          st_d  = cies_pkg::ST_ARB;
        end
      end
      cies_pkg::ST_RESUME: begin
        done_d = 1'b1;
        st_d   = cies_pkg::ST_IDLE;
      end
    endcase

    // Bus fields follow the next state so a new transfer starts at once
    mem_req_d   = 1'b0;
    mem_we_d    = 1'b0;
    mem_addr_d  = {ss_d, 4'h0} + {4'h0, sp_d};
    mem_wdata_d = cies_pkg::RESET_WORD;
    unique case (st_d)
      cies_pkg::ST_PUSH_PSW, cies_pkg::ST_PUSH_CS,
      cies_pkg::ST_PUSH_IP: begin
        mem_req_d  = 1'b1;
        mem_we_d   = 1'b1;
        mem_addr_d = {ss_d, 4'h0}
                     + {4'h0, sp_d - cies_pkg::STACK_STEP};
        if (st_d == cies_pkg::ST_PUSH_PSW) mem_wdata_d = psw_d;
        else if (st_d == cies_pkg::ST_PUSH_CS) mem_wdata_d = cs_d;
        else mem_wdata_d = ip_d;
      end
      cies_pkg::ST_RD_IP: begin
        mem_req_d  = 1'b1;
        mem_addr_d = {10'h000, vec_d, 2'b00} + cies_pkg::VEC_IP_OFS; // RL1
      end
      cies_pkg::ST_RD_CS: begin
        mem_req_d  = 1'b1;
        mem_addr_d = vec_base + cies_pkg::VEC_CS_OFS; // RL20
      end
      cies_pkg::ST_POP_IP, cies_pkg::ST_POP_CS,
      cies_pkg::ST_POP_PSW: begin
        mem_req_d = 1'b1;
      end
      default: begin
        mem_req_d = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q       <= cies_pkg::ST_IDLE;
      psw_q      <= cies_pkg::RESET_WORD;
      cs_q       <= cies_pkg::RESET_WORD;
      ip_q       <= cies_pkg::RESET_WORD;
      ss_q       <= cies_pkg::RESET_WORD;
      sp_q       <= cies_pkg::RESET_WORD;
      vec_q      <= 8'h00;
      exc_type_q <= 8'h00;
      exc_v_q    <= 1'b0;
      step_v_q   <= 1'b0;
      done_q     <= 1'b0;
      mem_req    <= 1'b0;
      mem_we     <= 1'b0;
      mem_addr   <= 20'h00000;
      mem_wdata  <= cies_pkg::RESET_WORD;
    end else begin
      st_q       <= st_d;
      psw_q      <= psw_d;
      cs_q       <= cs_d;
      ip_q       <= ip_d;
      ss_q       <= ss_d;
      sp_q       <= sp_d;
      vec_q      <= vec_d;
      exc_type_q <= exc_type_d;
      exc_v_q    <= exc_v_d;
      step_v_q   <= step_v_d;
      done_q     <= done_d;
      mem_req    <= mem_req_d;
      mem_we     <= mem_we_d;
      mem_addr   <= mem_addr_d;
      mem_wdata  <= mem_wdata_d;
    end
  end

  // Core must stall while busy; the return state is only valid with load
  assign seq_busy   = (st_q != cies_pkg::ST_IDLE) || done_q;
  assign intr_ack   = (st_q == cies_pkg::ST_ACK);
  assign load_valid = done_q;
  assign new_psw    = psw_q;
  assign new_cs     = cs_q;
  assign new_ip     = ip_q;
  assign new_sp     = sp_q;
endmodule : cies_sequencer

/* File: tb/cies_seq_chk.sv */
// Port timing checker for the interrupt and exception sequencer.
`timescale 1ns/1ns
module cies_seq_chk (
  input wire logic        ref_clk,
  input wire logic        rst,
  input wire logic        instr_done,
  input wire logic        intr_ack,
  input wire logic        intr_type_valid,
  input wire logic        seq_busy,
  input wire logic        load_valid,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic        mem_ack,
  input wire logic [19:0] mem_addr
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire wr_ok = mem_req && mem_we && mem_ack;
  wire rd_ok = mem_req && !mem_we && mem_ack;
  property p_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_hold: assert property (p_hold)
    else $error("bus request changed before ack");
  property p_idle; !seq_busy |-> !mem_req && !intr_ack; endproperty
  a_idle: assert property (p_idle)
    else $error("bus or ack active while idle");
  property p_take; instr_done && !seq_busy |=> seq_busy; endproperty
  a_take: assert property (p_take)
    else $error("boundary not taken");
  property p_ackw; intr_ack && !intr_type_valid |=> intr_ack; endproperty
  a_ackw: assert property (p_ackw)
    else $error("ack dropped before type");
  property p_push;
    intr_ack && intr_type_valid |=> mem_req && mem_we;
  endproperty
  a_push: assert property (p_push)
    else $error("no status push after type");
  property p_vec;
    wr_ok ##1 (mem_req && !mem_we) |->
      mem_addr[19:10] == 10'h000 && mem_addr[1:0] == 2'h0;
  endproperty
  a_vec: assert property (p_vec)
    else $error("vector read not at type times four");
  property p_down;
    wr_ok ##1 (mem_req && mem_we) |->
      mem_addr == $past(mem_addr) - 20'h00002;
  endproperty
  a_down: assert property (p_down)
    else $error("push address not two below");
  property p_up;
    rd_ok ##1 (mem_req && !mem_we) |->
      mem_addr == $past(mem_addr) + 20'h00002;
  endproperty
  a_up: assert property (p_up)
    else $error("read address not two above");
  property p_pulse; load_valid |=> !load_valid; endproperty
  a_pulse: assert property (p_pulse)
    else $error("load pulse too long");
  c_load: cover property (load_valid);
  c_ack: cover property (intr_ack && intr_type_valid);
  c_vec: cover property (rd_ok && mem_addr[19:10] == 10'h000);
endmodule : cies_seq_chk

bind cies_sequencer cies_seq_chk chk_u (.ref_clk(ref_clk), .rst(rst),
  .instr_done(instr_done), .intr_ack(intr_ack),
  .intr_type_valid(intr_type_valid), .seq_busy(seq_busy),
  .load_valid(load_valid), .mem_req(mem_req), .mem_we(mem_we),
  .mem_ack(mem_ack), .mem_addr(mem_addr));

/* File: tb/cies_far.sv */
// Memory and interrupt controller model facing the sequencer.
`timescale 1ns/1ns
module cies_far (
  input wire logic        ref_clk,
  input wire logic [1:0]  lat,
  input wire logic [7:0]  irq_type,
  input wire logic        intr_ack,
  output logic            intr_type_valid,
  output logic [7:0]      intr_type,
  input wire logic        mem_req,
  input wire logic        mem_we,
  input wire logic [19:0] mem_addr,
  input wire logic [15:0] mem_wdata,
  output logic            mem_ack,
  output logic [15:0]     mem_rdata
);
  logic [15:0] mem [0:2047];
  logic [1:0]  mcnt_q = 2'h0;
  logic [1:0]  icnt_q = 2'h0;
  logic [15:0] last_q = 16'h0000;
  // Unwritten words hold a pattern of their own address
  initial for (int i = 0; i < 2048; i++) mem[i] = 16'(i) ^ 16'h5A5A;
  assign mem_ack = mem_req && mcnt_q == lat;
  // Released data shows the inverse, never a stale copy
  assign mem_rdata = mem_ack ? mem[mem_addr[10:0]] : ~last_q;
  assign intr_type_valid = intr_ack && icnt_q == lat;
  assign intr_type = intr_type_valid ? irq_type : ~irq_type;
  always @(posedge ref_clk) begin
    mcnt_q <= (mem_ack || !mem_req) ? 2'h0 : mcnt_q + 2'h1;
    icnt_q <= (intr_type_valid || !intr_ack) ? 2'h0 : icnt_q + 2'h1;
    if (mem_ack) last_q <= mem_rdata;
    if (mem_ack && mem_we) mem[mem_addr[10:0]] <= mem_wdata;
  end
endmodule : cies_far

/* File: tb/cies_sequencer_tb.sv */
// Self-checking bench for the interrupt and exception sequencer.
`timescale 1ns/1ns
module cies_sequencer_tb;
  localparam logic [15:0] SP = 16'h0200;
  localparam logic [15:0] IP = 16'h0100;
  localparam logic [15:0] NIP = 16'h0103;
  logic        ref_clk = 1'b0, rst = 1'b1, nmi_pin = 1'b0, intr_req = 1'b0;
  logic        instr_done = 1'b0, return_from_handler_req = 1'b0, no_step_instr = 1'b0;
  logic        div_error = 1'b0, undef_opcode = 1'b0, sw_int = 1'b0;
  logic        fault_req = 1'b0;
  logic [7:0]  sw_type = 8'h00, fault_type = 8'h00, irq_type = 8'h00;
  logic [15:0] cur_psw = 16'h0000, cur_cs = 16'h2000, cur_ip = IP;
  logic [15:0] next_ip = NIP, cur_ss = 16'h0040, cur_sp = SP;
  logic [1:0]  lat = 2'h0;
  wire         intr_ack, intr_type_valid, seq_busy, load_valid;
  wire         mem_req, mem_we, mem_ack;
  wire  [7:0]  intr_type;
  wire  [15:0] new_psw, new_cs, new_ip, new_sp, mem_wdata, mem_rdata;
  wire  [19:0] mem_addr;
  int          fails = 0, n_checks = 0, acks = 0, a;

  always #20 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (intr_ack === 1'b1) acks++;
  cies_sequencer dut_u (
    .ref_clk         (ref_clk),
    .rst             (rst),
    .nmi_pin         (nmi_pin),
    .intr_req        (intr_req),
    .intr_ack        (intr_ack),
    .intr_type_valid (intr_type_valid),
    .intr_type       (intr_type),
    .instr_done      (instr_done),
    .return_from_handler_req        (return_from_handler_req),
    .no_step_instr   (no_step_instr),
    .div_error       (div_error),
    .undef_opcode    (undef_opcode),
    .sw_int          (sw_int),
    .sw_type         (sw_type),
    .fault_req       (fault_req),
    .fault_type      (fault_type),
    .cur_psw         (cur_psw),
    .cur_cs          (cur_cs),
    .cur_ip          (cur_ip),
    .next_ip         (next_ip),
    .cur_ss          (cur_ss),
    .cur_sp          (cur_sp),
    .seq_busy        (seq_busy),
    .load_valid      (load_valid),
    .new_psw         (new_psw),
    .new_cs          (new_cs),
    .new_ip          (new_ip),
    .new_sp          (new_sp),
    .mem_req         (mem_req),
    .mem_we          (mem_we),
    .mem_addr        (mem_addr),
    .mem_wdata       (mem_wdata),
    .mem_ack         (mem_ack),
    .mem_rdata       (mem_rdata)
  );
  cies_far far_u (
    .ref_clk         (ref_clk),
    .lat             (lat),
    .irq_type        (irq_type),
    .intr_ack        (intr_ack),
    .intr_type_valid (intr_type_valid),
    .intr_type       (intr_type),
    .mem_req         (mem_req),
    .mem_we          (mem_we),
    .mem_addr        (mem_addr),
    .mem_wdata       (mem_wdata),
    .mem_ack         (mem_ack),
    .mem_rdata       (mem_rdata)
  );

  task automatic chk(input logic [19:0] s, e);
    n_checks++;
    if (s !== e) begin
      fails++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, s, e);
    end
  endtask : chk

  function automatic logic [15:0] vec(input logic [19:0] adr);
    return adr[15:0] ^ 16'h5A5A;
  endfunction : vec

  task automatic bnd(input logic ir);
    @(posedge ref_clk);
    instr_done <= !ir;
    return_from_handler_req <= ir;
    @(posedge ref_clk);
    {instr_done, return_from_handler_req, div_error, undef_opcode, sw_int} <= 5'h00;
    {fault_req, no_step_instr} <= 2'h0;
    for (int k = 0; k < 300 && load_valid !== 1'b1; k++) @(posedge ref_clk);
    chk(load_valid, 1'b1);
  endtask : bnd

  // Entry, then return; kind 5 raises nothing of its own
  task automatic t_vec(input int kd, input logic [7:0] t,
                       input logic [15:0] program_status_word, ret);
    cur_psw <= program_status_word;
    cur_sp <= SP;
    sw_type <= t;
    fault_type <= t;
    div_error <= kd == 0;
    undef_opcode <= kd == 1;
    sw_int <= kd == 2;
    fault_req <= kd == 3;
    bnd(1'b0);
    intr_req <= 1'b0;
    chk(new_ip, vec({t, 2'h0}));
    chk(new_cs, vec({t, 2'h2}));
    chk(new_psw, program_status_word & 16'hFCFF);
    chk(new_sp, SP - 16'h0006);
    cur_sp <= SP - 16'h0006;
    bnd(1'b1);
    chk(new_ip, ret);
    chk(new_cs, cur_cs);
    chk(new_psw, program_status_word);
    chk(new_sp, SP);
  endtask : t_vec

  task automatic t_plain;
    cur_psw <= 16'h0100;
    no_step_instr <= 1'b1;
    bnd(1'b0);
    chk(new_ip, NIP);
    chk(new_psw, 16'h0100);
    $display("plain boundary test done");
  endtask : t_plain

  task automatic t_exc;
    t_vec(0, 8'h00, 16'h0200, NIP);
    t_vec(1, 8'h06, 16'h0200, NIP);
    t_vec(2, 8'hA5, 16'h0200, NIP);
    t_vec(3, 8'h07, 16'h0200, IP);
    t_vec(4, 8'h01, 16'h0300, NIP);
    $display("exception test done");
  endtask : t_exc

  task automatic t_mask;
    a = acks;
    cur_psw <= 16'h0000;
    intr_req <= 1'b1;
    irq_type <= 8'h40;
    lat <= 2'h3;
    bnd(1'b0);
    chk(20'(acks - a), 20'h0);
    t_vec(5, 8'h40, 16'h0200, NIP);
    chk(20'(acks > a), 20'h1);
    lat <= 2'h0;
    $display("maskable test done");
  endtask : t_mask

  task automatic t_nmi;
    a = acks;
    cur_psw <= 16'h0200;
    cur_sp <= SP;
    intr_req <= 1'b1;
    repeat (2) begin
      nmi_pin <= 1'b1;
      repeat (3) @(posedge ref_clk);
      nmi_pin <= 1'b0;
      repeat (3) @(posedge ref_clk);
    end
    bnd(1'b0);
    intr_req <= 1'b0;
    chk(new_ip, vec(20'h00008));
    chk(new_sp, SP - 16'h000C);
    chk(20'(acks - a), 20'h0);
    $display("non-maskable test done");
  endtask : t_nmi

  task automatic close_out;
    $display("checks %0d, mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : close_out

  initial begin
    repeat (6) @(posedge ref_clk);
    rst <= 1'b0;
    t_plain;
    t_exc;
    t_mask;
    t_nmi;
    close_out;
  end

  // Whole run needs a few hundred cycles
  initial begin
    #2000000;
    fails++;
    close_out;
  end
endmodule : cies_sequencer_tb
